// ---- lnb_supply_i2c_regs.sv ----
// Two-wire slave register bank of the LNB supply controller
// ----------------------------------------------------------------------
// Behaviour
// R1 - Master writes chip, register address, data, stop
// R2 - Further write bytes go to next register
// R3 - Slave acknowledges every received byte
// R4 - Accept writes until stop, any start address
// R5 - Master sets address, stops, then reads
// R6 - Send register; master ack advances to next
// R7 - Master ends read with nack then stop
// R8 - Control registers read back last write
// R9 - Register 2 holds four-bit level selector
// R10 - All registers zero at power-on
// R11 - Tone enable bit gates tone output
// R12 - Low-power bit; software avoids during tone
// R13 - Tone input role: external tone or envelope
// R14 - Output limit range and switch limit select
// R15 - Pulsed current limiting disable bit
// R16 - Pulsed limit on-time select bit
// R17 - Current monitor diagnostic enable bit
// R18 - Overload policy: latch-clear or auto-restore
// R19 - Overtemperature policy: latch-clear or auto-restore
// R20 - Status registers 0 and 1 read-only
// R21 - Primary status bits 0,2,4,6,7
// R22 - Tone and current status bits 0,2,4
// R23 - Level zero disables output, standby
// R24 - Slave address 0001000 or 0001001 by pin
// R25 - Reserved status bits zero; reserved stored
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "lnb_params.svh"
module lnb_supply_i2c_regs
  import lnb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrPin,
  // Analog monitor inputs
  input wire logic overload_flag,
  input wire logic out_voltage_low_flag,
  input wire logic pulldown_overcurrent_flag,
  input wire logic overtemp_flag,
  input wire logic supply_low_flag,
  input wire logic tone_detect_input,
  input wire logic tone_out_of_spec_flag,
  input wire logic current_monitor_flag,
  // Control outputs to the analog blocks
  output logic [3:0] outLevel,
  output logic tone_enable,
  output logic low_power_sel,
  output logic tone_input_role,
  output logic out_limit_low_range,
  output logic switch_limit_sel,
  output logic pulsed_limit_off,
  output logic timerLongSel,
  output logic current_monitor_enable,
  output logic overload_latch_policy,
  output logic overtemp_latch_policy,
  output logic compHighEsr
);
  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic sclS; // Synchronised clock line
  logic sdaS; // Synchronised data line
  logic addrS; // Synchronised address strap
  logic [7:0] statIn; // Raw monitor bits packed
  logic [7:0] statS; // Synchronised monitor bits

  sync2 u_sync_scl (.clk(clk), .rst(rst), .din(sclIn), .dout(sclS));
  sync2 u_sync_sda (.clk(clk), .rst(rst), .din(sdaIn), .dout(sdaS));
  sync2 u_sync_adr (.clk(clk), .rst(rst), .din(addrPin), .dout(addrS));

  assign statIn = {overload_flag, out_voltage_low_flag,
                   pulldown_overcurrent_flag, overtemp_flag,
                   supply_low_flag, tone_detect_input,
                   tone_out_of_spec_flag, current_monitor_flag};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      sync2 u_sync (.clk(clk), .rst(rst), .din(statIn[gi]),
                    .dout(statS[gi]));
    end
  endgenerate

  // Named views of the synchronised monitors
  logic olfS, vmonS, pdoS, otfS, lpdS, detS, tmonS, imonS;
  assign {olfS, vmonS, pdoS, otfS, lpdS, detS, tmonS, imonS} = statS;

  // ----------------------------------------------------------------------
  // Bus edge and condition detection
  // ----------------------------------------------------------------------
  logic sclPrev_q; // Previous synchronised clock
  logic sdaPrev_q; // Previous synchronised data
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  assign sclRise = sclS && !sclPrev_q;
  assign sclFall = !sclS && sclPrev_q;
  // Data moving while the clock is high marks a frame boundary
  assign startCond = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  assign stopCond = sclS && sclPrev_q && !sdaPrev_q && sdaS;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Next register pointer; wraps past the last register to keep in map
  function automatic logic [2:0] nextPtr(input logic [2:0] p);
    if (p >= `REG_LAST) begin
      nextPtr = 3'h0;
    end else begin
      nextPtr = p + 3'h1;
    end
  endfunction : nextPtr

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] levelReg_q; // Output level control
  logic [7:0] toneReg_q; // Tone and power control
  logic [7:0] limitReg_q; // Current limit control
  logic [7:0] protReg_q; // Protection policy control

  // ----------------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------------
  slave_state_t state_q;
  logic [3:0] bitCnt_q; // Bits seen in current byte, 0..8; 4'hf marks a read reload
  logic [7:0] shift_q; // Receive / transmit shift register
  logic [2:0] ptr_q; // Register pointer
  logic ackPhase_q; // Slave is driving the ack slot
  logic readMode_q; // Current frame is a read
  logic wrStrobe; // Data byte completed for writing
  logic [7:0] rdData; // Currently addressed register value
  logic [6:0] myAddr;

  assign myAddr = `SLAVE_ADDR_BASE | {6'h00, addrS}; // [R24]

  // Readback mux; reserved status bits read zero [R25]
  always_comb begin
    if (ptr_q == `REG_DIAG_PRIMARY) begin
      rdData = {lpdS, otfS, 1'b0, pdoS, 1'b0, vmonS, 1'b0, olfS}; // [R21]
    end else if (ptr_q == `REG_DIAG_TONE) begin
      rdData = {3'h0, imonS, 1'b0, tmonS, 1'b0, detS}; // [R22]
    end else if (ptr_q == `REG_OUT_LEVEL) begin
      rdData = levelReg_q; // [R8]
    end else if (ptr_q == `REG_TONE_POWER) begin
      rdData = toneReg_q;
    end else if (ptr_q == `REG_CUR_LIMIT) begin
      rdData = limitReg_q;
    end else if (ptr_q == `REG_PROTECT) begin
      rdData = protReg_q;
    end else begin
      rdData = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Byte engine: shifts in on rising clock, shifts out and acts on the falling edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SL_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 3'h0;
      ackPhase_q <= 1'b0;
      readMode_q <= 1'b0;
    end else if (startCond) begin
      // Repeated or fresh start: listen for chip address
      state_q <= SL_CHIP;
      bitCnt_q <= 4'h0;
      ackPhase_q <= 1'b0;
    end else if (stopCond) begin
      // Stop ends any frame; pointer is kept for the next read [R4]
      state_q <= SL_IDLE;
      ackPhase_q <= 1'b0;
    end else begin
      case (state_q)
        SL_IDLE: begin
          ackPhase_q <= 1'b0;
        end
        SL_RDATA: begin
          if (sclFall && !ackPhase_q) begin
            if (bitCnt_q == 4'hf) begin
              // Master ack slot over: load the advanced register [R6]
              shift_q <= rdData;
              bitCnt_q <= 4'h0;
            end else if (bitCnt_q == 4'h8) begin
              state_q <= SL_RACK; // Release and sample master ack
              bitCnt_q <= 4'h0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end else if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        SL_RACK: begin
          if (sclRise) begin
            if (!sdaS) begin
              // Master acked: advance and send next [R6]
              ptr_q <= nextPtr(ptr_q);
              state_q <= SL_RDATA;
              bitCnt_q <= 4'hf;
            end else begin
              state_q <= SL_IDLE; // Nack ends the read [R7]
            end
          end
        end
        default: begin
          // Receiving states: chip, register address, write data
          if (sclRise && !ackPhase_q) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && ackPhase_q) begin
            // Ack slot over: release the line
            ackPhase_q <= 1'b0;
            bitCnt_q <= 4'h0;
            if (readMode_q && state_q == SL_CHIP) begin
              state_q <= SL_RDATA;
              shift_q <= rdData;
              bitCnt_q <= 4'h0;
            end else if (state_q == SL_CHIP) begin
              state_q <= SL_REGADDR;
            end else begin
              state_q <= SL_WDATA;
            end
          end else if (sclFall && bitCnt_q == 4'h8) begin
            if (state_q == SL_CHIP) begin
              if (shift_q[7:1] == myAddr) begin
                ackPhase_q <= 1'b1; // [R3]
                readMode_q <= shift_q[0];
              end else begin
                state_q <= SL_IDLE; // Not ours: stay silent
              end
            end else if (state_q == SL_REGADDR) begin
              ptr_q <= shift_q[2:0];
              ackPhase_q <= 1'b1; // [R3]
            end else begin
              ackPhase_q <= 1'b1; // [R3] [R4]
            end
          end else if (state_q == SL_WDATA && sclRise && ackPhase_q) begin
            ptr_q <= nextPtr(ptr_q); // Next byte to next register [R2]
          end
        end
      endcase
    end
  end

  // A write lands in the ack cycle opening edge of a data byte
  assign wrStrobe = (state_q == SL_WDATA) && sclFall && !ackPhase_q &&
                    (bitCnt_q == 4'h8) && !startCond && !stopCond;

  // Reload of shift register after ack in read mode uses the pointer of
  // the rising ack edge; bitCnt 4'hf marks the load cycle.
  logic loadPending;
  assign loadPending = (state_q == SL_RDATA) && (bitCnt_q == 4'hf);

  // ----------------------------------------------------------------------
  // Data line drive: ack slots and read bits, open-drain style
  // ----------------------------------------------------------------------
  logic txBit_q; // Registered line-low request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txBit_q <= 1'b0;
    end else if (ackPhase_q && state_q != SL_IDLE) begin
      txBit_q <= 1'b1; // Pull low to acknowledge [R3]
    end else if (state_q == SL_RDATA && !loadPending) begin
      txBit_q <= !shift_q[7];
    end else begin
      txBit_q <= 1'b0;
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe = txBit_q;

  // ----------------------------------------------------------------------
  // Control registers: written through the data phase; latch policy also clears the level nibble
  // ----------------------------------------------------------------------
  logic overloadClear; // Latch policy wipes level on overload
  logic overtempClear; // Latch policy wipes level on overtemp
  assign overloadClear = olfS && protReg_q[`OVERLOAD_POLICY_BIT]; // [R18]
  assign overtempClear = otfS && protReg_q[`OVERTEMP_POLICY_BIT]; // [R19]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levelReg_q <= `CTRL_RESET; // [R10]
      toneReg_q <= `CTRL_RESET;
      limitReg_q <= `CTRL_RESET;
      protReg_q <= `CTRL_RESET;
    end else begin
      if (wrStrobe && ptr_q == `REG_OUT_LEVEL) begin
        levelReg_q <= {shift_q[7:4], shift_q[3:0]}; // [R9] [R25]
      end else if (overloadClear || overtempClear) begin
        levelReg_q <= {levelReg_q[7:4], 4'h0}; // [R18] [R19]
      end
      if (wrStrobe && ptr_q == `REG_TONE_POWER) begin
        toneReg_q <= shift_q;
      end
      if (wrStrobe && ptr_q == `REG_CUR_LIMIT) begin
        limitReg_q <= shift_q;
      end
      if (wrStrobe && ptr_q == `REG_PROTECT) begin
        protReg_q <= shift_q;
      end
      // Status offsets have no storage, writes there are dropped [R20]
    end
  end


  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  level_guard u_guard (
    .levelSel(levelReg_q[3:0]),
    .overloadFlag(olfS),
    .overtempFlag(otfS),
    .levelOut(outLevel)
  );
  assign tone_enable = toneReg_q[0]; // [R11]
  assign low_power_sel = toneReg_q[1]; // [R12]
  assign tone_input_role = toneReg_q[2]; // [R13]
  assign out_limit_low_range = limitReg_q[0]; // [R14]
  assign switch_limit_sel = limitReg_q[1]; // [R14]
  assign pulsed_limit_off = limitReg_q[2]; // [R15]
  assign timerLongSel = limitReg_q[3]; // [R16]
  assign current_monitor_enable = protReg_q[0]; // [R17]
  assign overload_latch_policy = protReg_q[`OVERLOAD_POLICY_BIT];
  assign overtemp_latch_policy = protReg_q[`OVERTEMP_POLICY_BIT];
  assign compHighEsr = protReg_q[7];
endmodule : lnb_supply_i2c_regs

// ---- lnb_params.svh ----
// Constants for the supply-controller register bank and its two-wire port
`ifndef LNB_PARAMS_SVH
`define LNB_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_DIAG_PRIMARY 3'h0
`define REG_DIAG_TONE 3'h1
`define REG_OUT_LEVEL 3'h2
`define REG_TONE_POWER 3'h3
`define REG_CUR_LIMIT 3'h4
`define REG_PROTECT 3'h5
`define REG_LAST 3'h5
// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define CTRL_RESET 8'h00
`define OVERLOAD_POLICY_BIT 3
`define OVERTEMP_POLICY_BIT 6
`define SLAVE_ADDR_BASE 7'h08
`endif

// ---- lnb_pkg.sv ----
// Types shared by the register bank files
package lnb_pkg;
  // Two-wire slave protocol phases
  typedef enum logic [2:0] {
    SL_IDLE, SL_CHIP, SL_REGADDR, SL_WDATA, SL_RDATA, SL_RACK
  } slave_state_t;
endpackage : lnb_pkg

// ---- sync2.sv ----
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q; // First stage, read only by the second
  // ----------------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : sync2

// ---- level_guard.sv ----
// Output-level gating for overload and overtemperature recovery
`timescale 1ns/1ps
module level_guard (
  // Control inputs
  input wire logic [3:0] levelSel,
  input wire logic overloadFlag,
  input wire logic overtempFlag,
  // Gated level to the regulator
  output logic [3:0] levelOut
);
  // ----------------------------------------------------------------------
  // Auto-restore path: level held off while a fault is active
  // ----------------------------------------------------------------------
  always_comb begin
    if (overloadFlag || overtempFlag) begin
      levelOut = 4'h0; // Output disabled during fault [R18] [R19]
    end else begin
      levelOut = levelSel; // Zero code means standby [R23]
    end
  end
endmodule : level_guard

// ---- lnb_supply_i2c_regs_checker.sv ----
// Pin-level assertions for the supply-controller register bank
`timescale 1ns/1ps
module lnb_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Fault flags and policy bits
  input wire logic overload_flag,
  input wire logic overtemp_flag,
  input wire logic overload_latch_policy,
  input wire logic overtemp_latch_policy,
  // Outputs to the analog side
  input wire logic [3:0] outLevel,
  input wire logic tone_enable
);
  // ------------------------------------------------------------
  // Shared timing
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Flags cross two sync flops, so five cycles settle the gate
  sequence olTrip;
    (overload_latch_policy && overload_flag) [*5];
  endsequence
  sequence otTrip;
    (overtemp_latch_policy && overtemp_flag) [*5];
  endsequence
  // Flag gone long enough for an automatic restore to show
  sequence olGone;
    (!overload_flag) [*6];
  endsequence
  sequence otGone;
    (!overtemp_flag) [*6];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  open_drain_a: assert property (
    sdaOe |-> !sdaOut) else $error("SDA driven high");
  scl_high_steady_a: assert property (
    sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("SDA moved while SCL high");
  drive_bounded_a: assert property (
    $rose(sdaOe) |-> ##[1:100] !sdaOe) else $error("SDA held too long");
  reset_clear_a: assert property (
    $fell(rst) |-> outLevel == 4'h0 && !tone_enable && !sdaOe)
    else $error("Outputs not clear after reset");
  overload_gate_a: assert property (
    overload_flag [*5] |-> outLevel == 4'h0)
    else $error("Level kept during overload");
  overtemp_gate_a: assert property (
    overtemp_flag [*5] |-> outLevel == 4'h0)
    else $error("Level kept during overtemperature");
  overload_latch_a: assert property (
    olTrip ##1 olGone |-> outLevel == 4'h0)
    else $error("Level restored despite latch policy");
  overtemp_latch_a: assert property (
    otTrip ##1 otGone |-> outLevel == 4'h0)
    else $error("Level restored despite thermal latch");
endmodule : lnb_regs_checker

bind lnb_supply_i2c_regs lnb_regs_checker chk (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .overload_flag(overload_flag), .overtemp_flag(overtemp_flag),
  .overload_latch_policy(overload_latch_policy),
  .overtemp_latch_policy(overtemp_latch_policy),
  .outLevel(outLevel), .tone_enable(tone_enable)
);

// ---- bus_master_model.sv ----
// Two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sdaLine,
  output logic sclLine,
  output logic sdaLow
);
  // SCL rests high on its pull-up; it never toggles between frames
  initial begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
  end
  // Eighth bit periods, always on the falling clk edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // SDA falls while SCL is high
  task automatic startCond();
    hold(2);
    sdaLow = 1'b1;
    hold(2);
    sclLine = 1'b0;
  endtask : startCond
  // SDA rises while SCL is high
  task automatic stopCond();
    hold(2);
    sdaLow = 1'b1;
    hold(2);
    sclLine = 1'b1;
    hold(2);
    sdaLow = 1'b0;
    hold(4);
  endtask : stopCond
  // SDA changes mid-low and is sampled mid-high
  task automatic bitCycle(input logic b, output logic s);
    hold(2);
    sdaLow = !b;
    hold(2);
    sclLine = 1'b1;
    hold(2);
    s = sdaLine;
    hold(2);
    sclLine = 1'b0;
  endtask : bitCycle
  // MSB first, then a released slot for the slave's ack
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], s);
    end
    bitCycle(1'b1, s);
    ack = !s;
  endtask : sendByte
  // Ack low to go on, left high after the last byte
  task automatic recvByte(output logic [7:0] b, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, b[i]);
    end
    bitCycle(!more, s);
  endtask : recvByte
endmodule : bus_master_model

// ---- tb_lnb_supply_i2c_regs.sv ----
// Self-checking bench for the supply-controller register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    badCount++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module tb_lnb_supply_i2c_regs;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic addrPin = 1'b0;
  logic [7:0] mon = 8'h00; // Monitor flags in port order
  logic sclLine, sdaLow, sdaOut, sdaOe, sdaLine;
  logic [3:0] outLevel;
  logic [10:0] ctl; // Control bits, tone enable at bit 0
  int badCount = 0;
  int comparisons = 0;
  wire [6:0] chipAddr = {6'h04, addrPin};
  // Status table: status 0 in the high byte, status 1 in the low
  logic [15:0] stx [8] = '{16'h0100, 16'h0400, 16'h1000, 16'h4000,
    16'h8000, 16'h0001, 16'h0004, 16'h0010};
  // Released SDA floats high on its pull-up
  assign sdaLine = !sdaLow && (sdaOe ? sdaOut : 1'b1);
  always #50 clk = !clk;
  bus_master_model m (.clk(clk), .sdaLine(sdaLine), .sclLine(sclLine),
    .sdaLow(sdaLow));
  lnb_supply_i2c_regs dut (.clk(clk), .rst(rst), .sclIn(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPin(addrPin),
    .overload_flag(mon[0]), .out_voltage_low_flag(mon[1]),
    .pulldown_overcurrent_flag(mon[2]), .overtemp_flag(mon[3]),
    .supply_low_flag(mon[4]), .tone_detect_input(mon[5]),
    .tone_out_of_spec_flag(mon[6]), .current_monitor_flag(mon[7]),
    .outLevel(outLevel), .tone_enable(ctl[0]), .low_power_sel(ctl[1]),
    .tone_input_role(ctl[2]), .out_limit_low_range(ctl[3]),
    .switch_limit_sel(ctl[4]), .pulsed_limit_off(ctl[5]),
    .timerLongSel(ctl[6]), .current_monitor_enable(ctl[7]),
    .overload_latch_policy(ctl[8]), .overtemp_latch_policy(ctl[9]),
    .compHighEsr(ctl[10]));
  // ------------------------------------------------------------
  // Bus transactions
  // ------------------------------------------------------------
  task automatic wrRegs(input logic [7:0] ra, input logic [7:0] d [$]);
    logic ack;
    m.startCond();
    m.sendByte({chipAddr, 1'b0}, ack);
    `CHK("chip ack", 1'b1, ack)
    m.sendByte(ra, ack);
    `CHK("reg ack", 1'b1, ack)
    foreach (d[i]) begin
      m.sendByte(d[i], ack);
      `CHK("data ack", 1'b1, ack)
    end
    m.stopCond();
  endtask : wrRegs
  // Pointer set by a short write, then a fresh read frame
  task automatic rdRegs(input logic [7:0] ra, input logic [7:0] e [$]);
    logic ack;
    logic [7:0] b;
    m.startCond();
    m.sendByte({chipAddr, 1'b0}, ack);
    m.sendByte(ra, ack);
    m.stopCond();
    m.startCond();
    m.sendByte({chipAddr, 1'b1}, ack);
    `CHK("read ack", 1'b1, ack)
    foreach (e[i]) begin
      m.recvByte(b, i < e.size() - 1);
      `CHK("read byte", e[i], b)
    end
    m.stopCond();
  endtask : rdRegs
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic resetScan();
    `CHK("level", 4'h0, outLevel)
    `CHK("ctl", 11'h000, ctl)
    rdRegs(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
  endtask : resetScan
  // Reserved bits written in to see that they are kept
  task automatic ctrlBurst();
    wrRegs(8'h02, '{8'h9a, 8'h05, 8'h0f, 8'h81});
    `CHK("level", 4'ha, outLevel)
    `CHK("ctl", 11'h4fd, ctl)
    wrRegs(8'h03, '{8'h02, 8'h00, 8'h4a});
    `CHK("ctl", 11'h302, ctl)
    // Runs past the last register to see the pointer wrap to status
    rdRegs(8'h02, '{8'h9a, 8'h02, 8'h00, 8'h4a, 8'h00, 8'h00,
      8'h9a});
  endtask : ctrlBurst
  // One flag at a time so a swapped bit shows up
  task automatic statusScan();
    wrRegs(8'h00, '{8'hff});
    for (int k = 0; k < 8; k++) begin
      mon = 8'h01 << k;
      m.hold(4);
      rdRegs(8'h00, '{stx[k][15:8], stx[k][7:0]});
    end
    mon = 8'h00;
  endtask : statusScan
  task automatic addrSelect();
    logic ack;
    addrPin = 1'b1;
    m.startCond();
    m.sendByte(8'h10, ack);
    `CHK("foreign ack", 1'b0, ack)
    m.stopCond();
    wrRegs(8'h02, '{8'h03});
    `CHK("level", 4'h3, outLevel)
    addrPin = 1'b0;
  endtask : addrSelect
  // Both faults under both recovery policies
  task automatic protect();
    for (int f = 0; f < 2; f++) begin
      for (int p = 0; p < 2; p++) begin
        wrRegs(8'h02, '{8'h06, 8'h00, 8'h00,
          p ? (f ? 8'h40 : 8'h08) : 8'h00});
        mon = f ? 8'h08 : 8'h01;
        m.hold(20);
        `CHK("tripped level", 4'h0, outLevel)
        mon = 8'h00;
        m.hold(20);
        `CHK("recovered", p ? 4'h0 : 4'h6, outLevel)
        rdRegs(8'h02, '{p ? 8'h00 : 8'h06});
      end
    end
  endtask : protect
  // ------------------------------------------------------------
  // Verdict and run control
  // ------------------------------------------------------------
  task automatic stopTest();
    if (badCount == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stopTest
  initial begin
    m.hold(12);
    rst = 1'b0;
    m.hold(5);
    resetScan();
    ctrlBurst();
    statusScan();
    addrSelect();
    protect();
    stopTest();
  end
  // A hung handshake is cut short and counted
  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    stopTest();
  end
endmodule : tb_lnb_supply_i2c_regs
